/* File: design/dca_pkg.sv */
// shared constants and types for the chained attenuator serial port
package dca_pkg;
    // frame layout: address byte first, then attenuation byte, msb first
    localparam int          DCA_FRAME_BITS = 16;
    localparam int          DCA_BYTE_W     = 8;
    localparam int          DCA_NUM_CH     = 3;
    localparam int          DCA_ADDR_MSB   = 15;
    localparam int          DCA_ADDR_LSB   = 8;
    localparam int          DCA_ATTEN_MSB  = 7;
    localparam int          DCA_ATTEN_LSB  = 0;

    // channel address codes, indexed by channel
    localparam logic [7:0]  DCA_ADDR_CH1   = 8'h00;
    localparam logic [7:0]  DCA_ADDR_CH2   = 8'h01;
    localparam logic [7:0]  DCA_ADDR_CH3   = 8'h02;

    // any attenuation code at or above this mutes the channel
    localparam logic [7:0]  DCA_MUTE_MIN   = 8'h4F;
    // code held by every channel after power-up
    localparam logic [7:0]  DCA_ATTEN_RST  = 8'h4F;

    // number of devices in the chain the host drives
    localparam int          DCA_CHAIN_LEN  = 1;
    localparam int          DCA_CHAIN_BITS = DCA_FRAME_BITS * DCA_CHAIN_LEN;

    // host timing, system clock 20 MHz
    localparam int          DCA_SYS_CLK_NS = 50;
    localparam int          DCA_T_SETUP_NS = 150;
    localparam int          DCA_SETUP_INT  =
        (DCA_T_SETUP_NS + DCA_SYS_CLK_NS - 1) / DCA_SYS_CLK_NS;
    localparam logic [7:0]  DCA_SETUP_CYC  = 8'(DCA_SETUP_INT);
    // serial clock half period in system clocks
    localparam logic [7:0]  DCA_HALF_CYC   = 8'h02;
    localparam logic [7:0]  DCA_LAST_BIT   = 8'(DCA_CHAIN_BITS - 1);

    typedef enum logic [2:0] {
        DCA_H_IDLE,
        DCA_H_SETUP,
        DCA_H_LOW,
        DCA_H_HIGH,
        DCA_H_HOLD
    } dca_host_state_t;
endpackage

/* File: design/dca_link_if.sv */
// serial link between host controller and attenuator chain
`timescale 1ns/1ps
`default_nettype none
interface dca_link_if;
    logic sclk;     // serial clock, made by the host
    logic sdi;      // serial data into the first device
    logic sel;      // low while shifting, rise latches
    logic sdo;      // serial data out of the device

    modport host (
        output sclk,
        output sdi,
        output sel,
        input  sdo
    );

    modport dev (
        input  sclk,
        input  sdi,
        input  sel,
        output sdo
    );
endinterface
`default_nettype wire

/* File: design/dca_device.sv */
// attenuator end: serial shift register, latch and channel decode
// clock domains
// link side runs on the serial clock and does nothing but shift;
// the serial clock may stop between frames, so no link-side logic
// waits for an edge that might never come
// system side runs on sys_clk, syncs the select through two flops
// and owns every user output
//
// crossing
// the shift word is not synced bit by bit; it is copied once the
// synced select rise is seen, when the word has been quiet since
// the last serial clock rise
// limitation: the host must not lower the select and pulse the serial
// clock again before the copy, or a copy may catch a word in motion
//
// decode
// one decode cycle after the copy: address match per channel,
// mute compare once, only the matched channel takes the new code
// an unknown address changes no channel setting and raises a one-cycle flag
//
// reset
// asynchronous, stands in for power-up; every channel comes out
// muted and the synced select starts high so no false latch follows
//
// chaining
// sdo is the oldest held bit, updated on the same serial clock
// rise that takes sdi, so the next device samples the old value
// at that rise and the whole chain moves one place per clock
//
// outputs
// ch_atten keeps the raw code even while muted; ch_mute says
// whether the channel is cut off; last_frame, upd_pulse and
// addr_err are status for the user side
//
// timing
// a latch shows on the outputs four to five sys_clk edges after
// the select rises: two sync stages, the edge, the copy, decode
`timescale 1ns/1ps
`default_nettype none
module dca_device (
    input  wire logic                      sys_clk,
    input  wire logic                      rstn,
    dca_link_if.dev                        link,
    output logic [dca_pkg::DCA_NUM_CH-1:0][dca_pkg::DCA_BYTE_W-1:0] ch_atten,
    output logic [dca_pkg::DCA_NUM_CH-1:0] ch_mute,
    output logic [dca_pkg::DCA_FRAME_BITS-1:0] last_frame,
    output logic                           upd_pulse,
    output logic                           addr_err
);
    // link-side state, clocked by the serial clock
    typedef struct packed {
        logic [dca_pkg::DCA_FRAME_BITS-1:0] shift;
    } dca_lnk_st_t;

    // system-side state
    typedef struct packed {
        // select synchroniser and edge history
        logic                                                     sel_meta;
        logic                                                     sel_sync;
        logic                                                     sel_prev;
        // decode follows the copy by one cycle
        logic                                                     pend;
        // captured frame and per-channel settings
        logic [dca_pkg::DCA_FRAME_BITS-1:0]                       frame;
        logic [dca_pkg::DCA_NUM_CH-1:0][dca_pkg::DCA_BYTE_W-1:0]  atten;
        logic [dca_pkg::DCA_NUM_CH-1:0]                           mute;
        // one-cycle status pulses
        logic                                                     upd;
        logic                                                     err;
    } dca_sys_st_t;

    localparam logic [dca_pkg::DCA_NUM_CH-1:0][dca_pkg::DCA_BYTE_W-1:0] CH_CODE = {
        dca_pkg::DCA_ADDR_CH3,
        dca_pkg::DCA_ADDR_CH2,
        dca_pkg::DCA_ADDR_CH1
    };

    dca_lnk_st_t lnk_reg;
    dca_lnk_st_t lnk_next;
    dca_sys_st_t sys_reg;
    dca_sys_st_t sys_next;

    logic                              sel_rise;
    logic [dca_pkg::DCA_BYTE_W-1:0]    addr_byte;
    logic [dca_pkg::DCA_BYTE_W-1:0]    atten_byte;
    logic [dca_pkg::DCA_NUM_CH-1:0]    hit;
    // code at or above the mute threshold, shared by all channels
    logic                              code_mutes;
    // per-channel next values, built by the generate loop below
    logic [dca_pkg::DCA_NUM_CH-1:0][dca_pkg::DCA_BYTE_W-1:0] atten_nx;
    logic [dca_pkg::DCA_NUM_CH-1:0]    mute_nx;

    // link side: accumulate bits only, no decoding here
    always_comb begin
        lnk_next = lnk_reg;
        if (!link.sel) begin
            lnk_next.shift = {lnk_reg.shift[dca_pkg::DCA_FRAME_BITS-2:0],
                              link.sdi};
        end
    end

    // serial clock may stop outside frames; nothing here waits for an edge
    always_ff @(posedge link.sclk or negedge rstn) begin
        if (!rstn) begin
            lnk_reg <= '0;
        end else begin
            lnk_reg <= lnk_next;
        end
    end

    // oldest held bit goes onward to the next device in the chain
    assign link.sdo = lnk_reg.shift[dca_pkg::DCA_FRAME_BITS-1];

    // frame fields of the captured word
    assign addr_byte  = sys_reg.frame[dca_pkg::DCA_ADDR_MSB:dca_pkg::DCA_ADDR_LSB];
    assign atten_byte = sys_reg.frame[dca_pkg::DCA_ATTEN_MSB:dca_pkg::DCA_ATTEN_LSB];
    assign sel_rise   = sys_reg.sel_sync & ~sys_reg.sel_prev;

    // mute compare done once for whichever channel is hit
    assign code_mutes = (atten_byte >= dca_pkg::DCA_MUTE_MIN);

    // per channel: address match and next setting
    genvar gi;
    generate
        for (gi = 0; gi < dca_pkg::DCA_NUM_CH; gi++) begin : g_hit
            assign hit[gi] = (addr_byte == CH_CODE[gi]);
            // only the addressed channel moves, only in the decode cycle
            assign atten_nx[gi] = (sys_reg.pend && hit[gi]) ? atten_byte
                                                            : sys_reg.atten[gi];
            // mute holds until a code below the threshold is decoded
            assign mute_nx[gi]  = (sys_reg.pend && hit[gi]) ? code_mutes
                                                            : sys_reg.mute[gi];
        end
    endgenerate

    // system side: sync the select, capture the frame on its rise, decode
    always_comb begin
        sys_next          = sys_reg;
        sys_next.upd      = 1'b0;
        sys_next.err      = 1'b0;
        // first stage is read only by the second stage
        sys_next.sel_meta = link.sel;
        sys_next.sel_sync = sys_reg.sel_meta;
        sys_next.sel_prev = sys_reg.sel_sync;
        // the shift word is quiet while select is high, so it crosses
        // safely once the synced rise has been seen
        if (sel_rise) begin
            sys_next.frame = lnk_reg.shift;
            sys_next.pend  = 1'b1;
        end
        if (sys_reg.pend) begin
            sys_next.pend = 1'b0;
            sys_next.upd  = 1'b1;
            sys_next.err  = ~|hit;
            sys_next.atten = atten_nx;
            sys_next.mute  = mute_nx;
        end
    end

    // power-up forces every channel to mute
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            // select starts high: no false rise after reset
            sys_reg.sel_meta <= 1'b1;
            sys_reg.sel_sync <= 1'b1;
            sys_reg.sel_prev <= 1'b1;
            sys_reg.pend     <= 1'b0;
            sys_reg.frame    <= '0;
            // channels come up muted, as at power-up
            sys_reg.atten    <= {dca_pkg::DCA_NUM_CH{dca_pkg::DCA_ATTEN_RST}};
            sys_reg.mute     <= '1;
            sys_reg.upd      <= 1'b0;
            sys_reg.err      <= 1'b0;
        end else begin
            sys_reg <= sys_next;
        end
    end

    // user outputs straight from the state register
    assign ch_atten   = sys_reg.atten;
    assign ch_mute    = sys_reg.mute;
    assign last_frame = sys_reg.frame;
    assign upd_pulse  = sys_reg.upd;
    assign addr_err   = sys_reg.err;
endmodule
`default_nettype wire

/* File: design/dca_host.sv */
// host end: shifts a chain update out and latches it
`timescale 1ns/1ps
`default_nettype none
module dca_host (
    input  wire logic                          sys_clk,
    input  wire logic                          rstn,
    input  wire logic                          start,
    input  wire logic [dca_pkg::DCA_CHAIN_BITS-1:0] frame,
    output logic                               busy,
    output logic                               done,
    dca_link_if.host                           link
);
    typedef struct packed {
        dca_pkg::dca_host_state_t              state;
        logic [7:0]                            cnt;
        logic [7:0]                            bitn;
        logic [dca_pkg::DCA_CHAIN_BITS-1:0]    shreg;
        logic                                  sclk;
        logic                                  sdo;
        logic                                  sel;
        logic                                  busy;
        logic                                  done;
    } dca_host_st_t;

    dca_host_st_t st_reg;
    dca_host_st_t st_next;

    // serial clock is divided down from the system clock here
    always_comb begin
        st_next      = st_reg;
        st_next.done = 1'b0;
        st_next.cnt  = st_reg.cnt + 8'h01;
        case (st_reg.state)
            dca_pkg::DCA_H_IDLE: begin
                st_next.cnt = 8'h00;
                if (start) begin
                    st_next.shreg = frame;
                    st_next.sel   = 1'b0;
                    st_next.busy  = 1'b1;
                    st_next.state = dca_pkg::DCA_H_SETUP;
                end
            end
            dca_pkg::DCA_H_SETUP: begin
                // select low for the setup time before the first rise
                if (st_reg.cnt == dca_pkg::DCA_SETUP_CYC - 8'h01) begin
                    st_next.cnt   = 8'h00;
                    st_next.bitn  = 8'h00;
                    st_next.sdo   = st_reg.shreg[dca_pkg::DCA_CHAIN_BITS-1];
                    st_next.shreg = st_reg.shreg << 1;
                    st_next.state = dca_pkg::DCA_H_LOW;
                end
            end
            dca_pkg::DCA_H_LOW: begin
                if (st_reg.cnt == dca_pkg::DCA_HALF_CYC - 8'h01) begin
                    st_next.cnt   = 8'h00;
                    st_next.sclk  = 1'b1;
                    st_next.state = dca_pkg::DCA_H_HIGH;
                end
            end
            dca_pkg::DCA_H_HIGH: begin
                // data changes on the fall, devices sample on the rise
                if (st_reg.cnt == dca_pkg::DCA_HALF_CYC - 8'h01) begin
                    st_next.cnt  = 8'h00;
                    st_next.sclk = 1'b0;
                    if (st_reg.bitn == dca_pkg::DCA_LAST_BIT) begin
                        st_next.state = dca_pkg::DCA_H_HOLD;
                    end else begin
                        st_next.bitn  = st_reg.bitn + 8'h01;
                        st_next.sdo   = st_reg.shreg[dca_pkg::DCA_CHAIN_BITS-1];
                        st_next.shreg = st_reg.shreg << 1;
                        st_next.state = dca_pkg::DCA_H_LOW;
                    end
                end
            end
            dca_pkg::DCA_H_HOLD: begin
                // raise select only after the last bit
                if (st_reg.cnt == dca_pkg::DCA_HALF_CYC - 8'h01) begin
                    st_next.cnt   = 8'h00;
                    st_next.sel   = 1'b1;
                    st_next.busy  = 1'b0;
                    st_next.done  = 1'b1;
                    st_next.state = dca_pkg::DCA_H_IDLE;
                end
            end
            default: begin
                st_next = st_reg;
                st_next.state = dca_pkg::DCA_H_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg.state <= dca_pkg::DCA_H_IDLE;
            st_reg.cnt   <= 8'h00;
            st_reg.bitn  <= 8'h00;
            st_reg.shreg <= '0;
            st_reg.sclk  <= 1'b0;
            st_reg.sdo   <= 1'b0;
            st_reg.sel   <= 1'b1;
            st_reg.busy  <= 1'b0;
            st_reg.done  <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign link.sclk = st_reg.sclk;
    assign link.sdi  = st_reg.sdo;
    assign link.sel  = st_reg.sel;
    assign busy      = st_reg.busy;
    assign done      = st_reg.done;
endmodule
`default_nettype wire

/* File: testbench/dca_link_asserts.sv */
// link checks between the host and attenuator ends
`timescale 1ns/1ps
`default_nettype none
module dca_link_asserts (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic sel,
    input wire logic sdo
);
    logic [5:0]  cnt_reg;
    logic [15:0] shadow_reg;

    // copy of the device shift word and a bit count; clearing the count on sel catches stray bits
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_reg <= 6'h00;
            shadow_reg <= 16'h0000;
        end else if (sel) begin
            cnt_reg <= 6'h00;
        end else if ($rose(sclk)) begin
            cnt_reg <= cnt_reg + 6'h01;
            shadow_reg <= {shadow_reg[14:0], sdi};
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    sequence setup_gap;
        !sclk [*3];
    endsequence
    sequence clk_pulse;
        sclk ##1 sclk ##1 !sclk;
    endsequence

    chk_sel_setup: assert property ($fell(sel) |-> setup_gap)
        else $error("sclk too soon after sel fall");
    chk_clk_idle: assert property (sel |-> !sclk)
        else $error("sclk high while sel high");
    chk_clk_shape: assert property ($rose(sclk) |-> clk_pulse)
        else $error("sclk pulse width");
    chk_sdi_settled: assert property ($changed(sdi) |-> !sclk)
        else $error("sdi moved while sclk high");
    chk_bit_count: assert property ($rose(sel) |-> cnt_reg == 6'h10)
        else $error("bit count at latch");
    chk_sel_held: assert property (!sel && cnt_reg != 6'h10 |=> !sel)
        else $error("sel rose mid frame");
    chk_sdo_shift: assert property ($rose(sclk) |-> sdo == shadow_reg[14])
        else $error("sdo not previous bit");
    chk_sdo_quiet: assert property ($changed(sdo) |-> $rose(sclk))
        else $error("sdo moved without sclk");
endmodule
`default_nettype wire

/* File: testbench/daisy_chain_attenuator_serial_port_tb.sv */
// bench joining host and attenuator ends over the link
`timescale 1ns/1ps
`default_nettype none
module daisy_chain_attenuator_serial_port_tb;
    logic        sys_clk;
    logic        rstn;
    logic        start;
    logic [15:0] frame;
    logic        busy;
    logic        done;
    logic [2:0][7:0] ch_atten;
    logic [2:0]  ch_mute;
    logic [15:0] last_frame;
    logic        upd_pulse;
    logic        addr_err;
    logic [7:0]  exp_atten [3];
    logic        exp_mute [3];
    int          fails;
    int          total_checks;

    dca_link_if link ();
    dca_host u_dca_host (.sys_clk(sys_clk), .rstn(rstn), .start(start), .frame(frame),
        .busy(busy), .done(done), .link(link));
    dca_device u_dca_device (.sys_clk(sys_clk), .rstn(rstn), .link(link),
        .ch_atten(ch_atten), .ch_mute(ch_mute), .last_frame(last_frame),
        .upd_pulse(upd_pulse), .addr_err(addr_err));
    dca_link_asserts u_dca_link_asserts (.sys_clk(sys_clk), .rstn(rstn),
        .sclk(link.sclk), .sdi(link.sdi), .sel(link.sel), .sdo(link.sdo));

    // system clock, 50 ns period
    always #25 sys_clk = ~sys_clk;

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // bounded poll; a one-cycle pulse is still visible at the falling edge
    task automatic wait_high(input string what, ref logic sig, input int limit);
        int n;
        n = 0;
        while (sig !== 1'b1 && n < limit) begin
            @(negedge sys_clk);
            n++;
        end
        if (sig !== 1'b1) begin
            fails++;
            $display("BAD %s expected 1 seen timeout", what);
            print_verdict();
        end
    endtask

    task automatic check_all();
        for (int i = 0; i < 3; i++) begin
            chk_val("ch_atten", 16'(exp_atten[i]), 16'(ch_atten[i]));
            chk_val("ch_mute", 16'(exp_mute[i]), 16'(ch_mute[i]));
        end
    endtask

    // one update through the host, judged at the decode pulse
    task automatic send(input logic [7:0] addr, input logic [7:0] code);
        frame = {addr, code};
        start = 1'b1;
        @(negedge sys_clk);
        start = 1'b0;
        chk_val("busy", 16'h0001, 16'(busy));
        wait_high("done", done, 200);
        chk_val("busy", 16'h0000, 16'(busy));
        wait_high("upd_pulse", upd_pulse, 12);
        chk_val("addr_err", 16'(addr > 8'h02), 16'(addr_err));
        chk_val("last_frame", {addr, code}, last_frame);
        if (addr <= 8'h02) begin
            exp_atten[addr[1:0]] = code;
            exp_mute[addr[1:0]] = (code >= dca_pkg::DCA_MUTE_MIN);
        end
        check_all();
        // sel must idle high a few cycles before the next frame
        repeat (8) @(negedge sys_clk);
    endtask

    task automatic t_channels();
        for (int i = 0; i < 3; i++) begin
            send(8'(i), 8'(8'h10 + i));
        end
    endtask

    task automatic t_mute_edge();
        send(8'h01, 8'h4E);
        send(8'h01, 8'h4F);
        send(8'h01, 8'h00);
        send(8'h01, 8'hFF);
    endtask

    task automatic t_bad_addr();
        send(8'h03, 8'h00);
        send(8'h80, 8'h20);
    endtask

    // main sequence
    initial begin
        sys_clk = 1'b0;
        rstn = 1'b0;
        start = 1'b0;
        frame = 16'h0000;
        fails = 0;
        total_checks = 0;
        for (int i = 0; i < 3; i++) begin
            exp_atten[i] = dca_pkg::DCA_ATTEN_RST;
            exp_mute[i] = 1'b1;
        end
        repeat (8) @(negedge sys_clk);
        rstn = 1'b1;
        repeat (4) @(negedge sys_clk);
        check_all();
        t_channels();
        t_mute_edge();
        t_bad_addr();
        print_verdict();
    end
endmodule
`default_nettype wire
